//--- speed_sup_defs.svh
// Register offsets, field layouts, reset values and timing counts of the speed supervisor.
`ifndef SPEED_SUP_DEFS_SVH
`define SPEED_SUP_DEFS_SVH
// Register byte offsets on the register bus.
`define OFF_CTRL 8'h00
`define OFF_NOTCH 8'h04
`define OFF_JCMD 8'h08
`define OFF_JDET 8'h0c
`define OFF_JGAIN 8'h10
`define OFF_JINT 8'h14
`define OFF_JOUT 8'h18
`define OFF_HYST 8'h1c
`define OFF_TMR 8'h20
`define OFF_PROC 8'h24
`define OFF_OFUNC0 8'h28
`define OFF_OFUNC1 8'h2c
`define OFF_STAT 8'h30
`define OFF_ISTAT 8'h34
`define OFF_IMASK 8'h38
// Control register fields.
`define CTRL_MOTOR_LSB 0
`define CTRL_MSEL_BIT 2
`define CTRL_PSW_LSB 3
`define CTRL_ARST_BIT 8
// Reset values, in the units of each field.
`define RST_JCMD 13'h0014
`define RST_JDET 7'h05
`define RST_JGAIN 11'h064
`define RST_JINT 14'h0064
`define RST_JOUT 7'h02
`define RST_HYST 9'h064
`define RST_TMR 10'h032
`define RST_PROC 3'h2
// Accepted ranges.
`define MAX_JCMD 32'h0000_1388
`define MAX_FILT 32'h0000_0064
`define MAX_JGAIN 32'h0000_07d0
`define MAX_JINT 32'h0000_270f
`define MAX_HYST 32'h0000_01f4
`define MAX_TMR 32'h0000_03e8
`define MAX_PROC 32'h0000_0005
`define MAX_ATT 8'h14
// Special codes.
`define INT_OFF_CODE 14'h03e7
`define FN_MATCH 8'h47
`define FN_FAULT 8'h4c
// Timing: detection tick of 10 ms at a 10 ns clock.
`define TICK_MS 10
`define CLK_NS 10
`define TICK_CYC (`TICK_MS * 1000000 / `CLK_NS)
`endif

//--- speed_sup_pkg.sv
// Types shared by the speed supervisor.
package speed_sup_pkg;
    // Supervision state after the persistence timer runs out.
    typedef enum logic [1:0] {SUP_OK, SUP_WARN, SUP_COAST} sup_state_t;
endpackage

//--- persist_timer.sv
// Persistence timer: counts ticks while a condition holds outside the band.
module persist_timer #(
    parameter int LIM_W = 10
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic tick,
    input wire logic outside,
    input wire logic [LIM_W-1:0] limit,
    output logic expired
);
    // Ticks counted since the condition left the band.
    logic [LIM_W-1:0] cnt_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_q <= '0;
        end else if (!outside) begin
            cnt_q <= '0;
        end else if (tick && cnt_q < limit) begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    // A zero limit expires as soon as the condition is outside.
    assign expired = outside && (cnt_q >= limit);

    chk_clear_inside: assert property (@(posedge aclk) disable iff (!aresetn)
        !outside |=> cnt_q == '0) else $error("timer not cleared inside band");
endmodule

//--- speed_loop_supervision.sv
// Speed loop supervision: notch routing, jog set, agreement and error detection.
//
// Local design decisions: the AXI4-Lite register port and the register addresses.
`include "speed_sup_defs.svh"
module speed_loop_supervision #(
    parameter int TICK_CYCLES = `TICK_CYC,
    parameter int NTERM = 6
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic jog_pin,
    input wire logic signed [15:0] ref_speed,
    input wire logic signed [15:0] det_speed,
    input wire logic [12:0] norm_cmd_filt,
    input wire logic [6:0] norm_det_filt,
    input wire logic [10:0] norm_gain,
    input wire logic [13:0] norm_itime,
    input wire logic [6:0] norm_out_filt,
    output logic [3:0] notch_en,
    output logic [12:0] sel_cmd_filt,
    output logic [6:0] sel_det_filt,
    output logic [10:0] sel_gain,
    output logic [13:0] sel_itime,
    output logic sel_integ_en,
    output logic [6:0] sel_out_filt,
    output logic speed_match_flag,
    output logic speed_fault_flag,
    output logic speed_fault_alarm,
    output logic coast_stop,
    output logic [1:0] alarm_variant,
    output logic [NTERM-1:0] term_out,
    output logic irq
);
    // Configuration registers written by software.
    logic [5:0] ctrl_q;
    logic [31:0] notch_q;
    logic [12:0] jcmd_q;
    logic [6:0] jdet_q;
    logic [10:0] jgain_q;
    logic [13:0] jint_q;
    logic [6:0] jout_q;
    logic [8:0] hyst_q;
    logic [9:0] tmr_q;
    logic [2:0] proc_q;
    logic [31:0] ofunc0_q;
    logic [15:0] ofunc1_q;
    logic [1:0] istat_q;
    logic [1:0] imask_q;
    // Bus handshake state.
    logic aw_hold_q, w_hold_q;
    logic [7:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic do_wr;
    logic [31:0] wr_val;
    logic wr_hit;
    logic alarm_rst;
    // Register views for the write merge and the read answer; bit 32 marks a mapped address.
    logic [32:0] wr_view;
    logic [32:0] rd_view;
    // All terminal function codes side by side, one byte per terminal.
    logic [47:0] ofunc_all;
    // Supervision state.
    logic jog_s1_q, jog_q;
    logic [$clog2(TICK_CYCLES+1)-1:0] div_q;
    logic tick;
    logic [16:0] dev;
    logic [16:0] abs_dev;
    logic out_band, err_out, exc_ok;
    logic match_exp, err_exp;
    logic stop_code;
    logic match_q;
    speed_sup_pkg::sup_state_t st_q;
    logic [1:0] ev;

    // Read view of every register; bit 32 marks a mapped address.
    function automatic logic [32:0] reg_rd(input logic [7:0] a);
        logic [32:0] r;
        r = 33'h0_0000_0000;
        if (a == `OFF_CTRL) begin
            r = {1'b1, 26'h0, ctrl_q};
        end else if (a == `OFF_NOTCH) begin
            r = {1'b1, notch_q};
        end else if (a == `OFF_JCMD) begin
            r = {1'b1, 19'h0, jcmd_q};
        end else if (a == `OFF_JDET) begin
            r = {1'b1, 25'h0, jdet_q};
        end else if (a == `OFF_JGAIN) begin
            r = {1'b1, 21'h0, jgain_q};
        end else if (a == `OFF_JINT) begin
            r = {1'b1, 18'h0, jint_q};
        end else if (a == `OFF_JOUT) begin
            r = {1'b1, 25'h0, jout_q};
        end else if (a == `OFF_HYST) begin
            r = {1'b1, 23'h0, hyst_q};
        end else if (a == `OFF_TMR) begin
            r = {1'b1, 22'h0, tmr_q};
        end else if (a == `OFF_PROC) begin
            r = {1'b1, 29'h0, proc_q};
        end else if (a == `OFF_OFUNC0) begin
            r = {1'b1, ofunc0_q};
        end else if (a == `OFF_OFUNC1) begin
            r = {1'b1, 16'h0, ofunc1_q};
        end else if (a == `OFF_STAT) begin
            r = {1'b1, 26'h0, alarm_variant, jog_q, coast_stop,
                 speed_fault_flag, speed_match_flag};
        end else if (a == `OFF_ISTAT) begin
            r = {1'b1, 30'h0, istat_q};
        end else if (a == `OFF_IMASK) begin
            r = {1'b1, 30'h0, imask_q};
        end
        return r;
    endfunction

    // Address and data are taken separately; a held one blocks its channel.
    assign s_axi_awready = !aw_hold_q && !s_axi_bvalid;
    assign s_axi_wready = !w_hold_q && !s_axi_bvalid;
    assign do_wr = aw_hold_q && w_hold_q && !s_axi_bvalid;
    assign wr_hit = wr_view[32];

    // Byte strobes merge new bytes into the current register view.
    // The views are built here so that every register the lookup reads is watched.
    always_comb begin
        wr_view = reg_rd(aw_addr_q);
        rd_view = reg_rd(s_axi_araddr);
        wr_val = wr_view[31:0];
        for (int b = 0; b < 4; b++) begin
            if (w_strb_q[b]) begin
                wr_val[8*b +: 8] = w_data_q[8*b +: 8];
            end
        end
    end

    // Alarm reset is a write-only pulse, never stored.
    assign alarm_rst = do_wr && aw_addr_q == `OFF_CTRL
        && w_strb_q[1] && w_data_q[`CTRL_ARST_BIT];

    // Write channel capture and response.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (do_wr) begin
                aw_hold_q <= 1'b0;
                w_hold_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                // Unmapped addresses answer with a slave error.
                s_axi_bresp <= wr_hit ? 2'h0 : 2'h2;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Read channel: one answer a cycle after the address is taken.
    assign s_axi_arready = !s_axi_rvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'h0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_view[31:0];
            s_axi_rresp <= rd_view[32] ? 2'h0 : 2'h2;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Configuration writes; a value outside its range leaves the field alone.
    // That keeps the regulator from ever seeing a setting it cannot use.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q <= 6'h00;
            notch_q <= 32'h0000_0000;
            jcmd_q <= `RST_JCMD;
            jdet_q <= `RST_JDET;
            jgain_q <= `RST_JGAIN;
            jint_q <= `RST_JINT;
            jout_q <= `RST_JOUT;
            hyst_q <= `RST_HYST;
            tmr_q <= `RST_TMR;
            proc_q <= `RST_PROC;
            ofunc0_q <= 32'h0000_0000;
            ofunc1_q <= 16'h0000;
            imask_q <= 2'h0;
        end else if (do_wr) begin
            if (aw_addr_q == `OFF_CTRL) begin
                ctrl_q <= wr_val[5:0];
            end else if (aw_addr_q == `OFF_NOTCH) begin
                if (wr_val[7:0] <= `MAX_ATT && wr_val[15:8] <= `MAX_ATT
                    && wr_val[23:16] <= `MAX_ATT && wr_val[31:24] <= `MAX_ATT) begin
                    notch_q <= wr_val;
                end
            end else if (aw_addr_q == `OFF_JCMD && wr_val <= `MAX_JCMD) begin
                jcmd_q <= wr_val[12:0];
            end else if (aw_addr_q == `OFF_JDET && wr_val <= `MAX_FILT) begin
                jdet_q <= wr_val[6:0];
            end else if (aw_addr_q == `OFF_JGAIN && wr_val != 32'h0
                         && wr_val <= `MAX_JGAIN) begin
                jgain_q <= wr_val[10:0];
            end else if (aw_addr_q == `OFF_JINT && wr_val != 32'h0
                         && wr_val <= `MAX_JINT) begin
                jint_q <= wr_val[13:0];
            end else if (aw_addr_q == `OFF_JOUT && wr_val <= `MAX_FILT) begin
                jout_q <= wr_val[6:0];
            end else if (aw_addr_q == `OFF_HYST && wr_val <= `MAX_HYST) begin
                hyst_q <= wr_val[8:0];
            end else if (aw_addr_q == `OFF_TMR && wr_val <= `MAX_TMR) begin
                tmr_q <= wr_val[9:0];
            end else if (aw_addr_q == `OFF_PROC && wr_val <= `MAX_PROC) begin
                proc_q <= wr_val[2:0];
            end else if (aw_addr_q == `OFF_OFUNC0) begin
                ofunc0_q <= wr_val;
            end else if (aw_addr_q == `OFF_OFUNC1) begin
                ofunc1_q <= wr_val[15:0];
            end else if (aw_addr_q == `OFF_IMASK) begin
                imask_q <= wr_val[1:0];
            end
        end
    end

    // Jog request comes from a pin, so it is synchronised first.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            jog_s1_q <= 1'b0;
            jog_q <= 1'b0;
        end else begin
            jog_s1_q <= jog_pin;
            jog_q <= jog_s1_q;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sel_cmd_filt <= 13'h0000;
            sel_det_filt <= 7'h00;
            sel_gain <= 11'h000;
            sel_itime <= 14'h0000;
            sel_integ_en <= 1'b0;
            sel_out_filt <= 7'h00;
        end else begin
            sel_cmd_filt <= jog_q ? jcmd_q : norm_cmd_filt;
            sel_det_filt <= jog_q ? jdet_q : norm_det_filt;
            sel_gain <= jog_q ? jgain_q : norm_gain;
            sel_itime <= jog_q ? jint_q : norm_itime;
            sel_integ_en <= (jog_q ? jint_q : norm_itime) != `INT_OFF_CODE;
            sel_out_filt <= jog_q ? jout_q : norm_out_filt;
        end
    end

    // Notch routing: one enable per filter.
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_notch
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    notch_en[gi] <= 1'b0;
                end else if (notch_q[8*gi +: 8] == 8'h00) begin
                    notch_en[gi] <= 1'b0;
                end else if (!ctrl_q[`CTRL_MSEL_BIT] || &ctrl_q[`CTRL_PSW_LSB +: 3]) begin
                    notch_en[gi] <= ctrl_q[1:0] == 2'h0;
                end else begin
                    notch_en[gi] <= ctrl_q[1:0] == 2'(gi);
                end
            end
        end
    endgenerate

    // Control-loop tick divider; one pulse every 10 ms.
    always_ff @(posedge aclk) begin
        if (!aresetn || tick) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + 1'b1;
        end
    end
    assign tick = div_q == ($bits(div_q))'(TICK_CYCLES - 1);

    // Deviation in tenths of a percent of maximum speed.
    assign dev = 17'(ref_speed) - 17'(det_speed);
    assign abs_dev = dev[16] ? 17'(-dev) : dev;
    assign out_band = abs_dev > 17'(hyst_q);
    // Codes 0, 1, 3 and 4 excuse a motor that only lags behind.
    assign exc_ok = proc_q != 3'h2 && proc_q != 3'h5 && det_speed < ref_speed;
    assign err_out = out_band && !exc_ok;
    assign stop_code = proc_q != 3'h0 && proc_q != 3'h3;

    // Agreement and error each keep their own persistence timer.
    persist_timer #(.LIM_W(10)) u_match_tmr (
        .aclk(aclk),
        .aresetn(aresetn),
        .tick(tick),
        .outside(out_band),
        .limit(tmr_q),
        .expired(match_exp)
    );
    persist_timer #(.LIM_W(10)) u_err_tmr (
        .aclk(aclk),
        .aresetn(aresetn),
        .tick(tick),
        .outside(err_out),
        .limit(tmr_q),
        .expired(err_exp)
    );

    // Agreement flag drops only when the timer runs out.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            match_q <= 1'b1;
        end else if (!out_band) begin
            match_q <= 1'b1;
        end else if (match_exp) begin
            match_q <= 1'b0;
        end
    end
    assign speed_match_flag = match_q;

    // Error handling: a warning follows the condition, a stop latches.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_q <= speed_sup_pkg::SUP_OK;
            alarm_variant <= 2'h0;
        end else begin
            case (st_q)
                speed_sup_pkg::SUP_OK: begin
                    if (err_exp && stop_code) begin
                        st_q <= speed_sup_pkg::SUP_COAST;
                        alarm_variant <= proc_q > 3'h3 ? 2'(proc_q - 3'h2)
                                                       : 2'(proc_q - 3'h1);
                    end else if (err_exp) begin
                        st_q <= speed_sup_pkg::SUP_WARN;
                    end
                end
                speed_sup_pkg::SUP_WARN: begin
                    if (!err_exp) begin
                        st_q <= speed_sup_pkg::SUP_OK;
                    end
                end
                speed_sup_pkg::SUP_COAST: begin
                    if (alarm_rst) begin
                        st_q <= speed_sup_pkg::SUP_OK;
                    end
                end
                default: st_q <= speed_sup_pkg::SUP_OK;
            endcase
        end
    end
    assign speed_fault_flag = st_q != speed_sup_pkg::SUP_OK;
    assign coast_stop = st_q == speed_sup_pkg::SUP_COAST;
    assign speed_fault_alarm = coast_stop;

    // Output terminals pick the flag that their function code names.
    assign ofunc_all = {ofunc1_q, ofunc0_q};
    generate
        for (gi = 0; gi < NTERM; gi++) begin : g_term
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    term_out[gi] <= 1'b0;
                end else if (ofunc_all[8*gi +: 8] == `FN_MATCH) begin
                    term_out[gi] <= match_q;
                end else if (ofunc_all[8*gi +: 8] == `FN_FAULT) begin
                    term_out[gi] <= speed_fault_flag;
                end else begin
                    term_out[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    // Sticky events: bit 0 error declared, bit 1 agreement lost.
    // A new event in the clearing cycle wins over the clear.
    assign ev = {match_q && out_band && match_exp,
                 st_q == speed_sup_pkg::SUP_OK && err_exp};
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            istat_q <= 2'h0;
        end else if (do_wr && aw_addr_q == `OFF_ISTAT && w_strb_q[0]) begin
            istat_q <= (istat_q & ~w_data_q[1:0]) | ev;
        end else begin
            istat_q <= istat_q | ev;
        end
    end
    assign irq = |(istat_q & imask_q);

    chk_notch_zero: assert property (@(posedge aclk) disable iff (!aresetn)
        notch_q[7:0] == 8'h00 |=> !notch_en[0]) else $error("zero dB filter enabled");
    chk_notch_route: assert property (@(posedge aclk) disable iff (!aresetn)
        ctrl_q[2] && !(&ctrl_q[5:3]) && ctrl_q[1:0] == 2'h1 && notch_q[7:0] != 8'h00
        |=> !notch_en[0]) else $error("filter one used on motor two");
    chk_jog_sel: assert property (@(posedge aclk) disable iff (!aresetn)
        jog_q && $stable(jog_q) && $stable(jgain_q) |=> sel_gain == $past(jgain_q))
        else $error("jog gain not selected");
    chk_int_off: assert property (@(posedge aclk) disable iff (!aresetn)
        jog_q && jint_q == `INT_OFF_CODE |=> !sel_integ_en) else $error("integral not off");
    chk_match_in: assert property (@(posedge aclk) disable iff (!aresetn)
        !out_band |=> speed_match_flag) else $error("agreement not set inside band");
    chk_match_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        match_q && out_band && !match_exp |=> match_q) else $error("agreement dropped early");
    chk_err_decl: assert property (@(posedge aclk) disable iff (!aresetn)
        st_q == speed_sup_pkg::SUP_OK && err_exp |=> speed_fault_flag)
        else $error("error not declared");
    chk_coast: assert property (@(posedge aclk) disable iff (!aresetn)
        st_q == speed_sup_pkg::SUP_OK && err_exp && proc_q == 3'h2
        |=> coast_stop && speed_fault_alarm) else $error("no coast on stop code");
    chk_cont: assert property (@(posedge aclk) disable iff (!aresetn)
        st_q == speed_sup_pkg::SUP_OK && proc_q == 3'h0 |=> !coast_stop)
        else $error("coast on continue code");
    chk_term_m: assert property (@(posedge aclk) disable iff (!aresetn)
        ofunc0_q[7:0] == `FN_MATCH |=> term_out[0] == $past(match_q))
        else $error("terminal does not show agreement");
    cov_coast: cover property (@(posedge aclk) disable iff (!aresetn) $rose(coast_stop));
    cov_warn: cover property (@(posedge aclk) disable iff (!aresetn)
        st_q == speed_sup_pkg::SUP_WARN);
    cov_match_loss: cover property (@(posedge aclk) disable iff (!aresetn) $fell(match_q));
endmodule

//--- tb_speed_loop_supervision.sv
// Self-checking bench for the speed loop supervision block over its register bus.
`include "speed_sup_defs.svh"
module tb_speed_loop_supervision;
timeunit 1ns;
timeprecision 1ps;
// Bus and block signals, named as the ports they connect to, plus the bench's own results and counters.
logic aclk = 0, aresetn = 0, jog_pin = 0;
logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
logic [31:0] s_axi_wdata = 32'h0, d;
logic [3:0] s_axi_wstrb = 4'hf;
logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
logic signed [15:0] ref_speed = 16'sh0, det_speed = 16'sh0;
logic [12:0] norm_cmd_filt = 13'h0007;
logic [6:0] norm_det_filt = 7'h03, norm_out_filt = 7'h04;
logic [10:0] norm_gain = 11'h02a;
logic [13:0] norm_itime = 14'h0050;
logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, sel_integ_en, irq;
logic [1:0] s_axi_bresp, s_axi_rresp, r, br, alarm_variant;
logic [31:0] s_axi_rdata;
logic [3:0] notch_en;
logic [12:0] sel_cmd_filt;
logic [6:0] sel_det_filt, sel_out_filt;
logic [10:0] sel_gain;
logic [13:0] sel_itime;
logic speed_match_flag, speed_fault_flag, speed_fault_alarm, coast_stop;
logic [5:0] term_out;
int miscompares = 0, tests_run = 0, cycles = 0;
// A short tick keeps the persistence timer within a brief run.
speed_loop_supervision #(.TICK_CYCLES(4), .NTERM(6)) u_dut (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .jog_pin, .ref_speed, .det_speed,
    .norm_cmd_filt, .norm_det_filt, .norm_gain, .norm_itime, .norm_out_filt, .notch_en,
    .sel_cmd_filt, .sel_det_filt, .sel_gain, .sel_itime, .sel_integ_en, .sel_out_filt,
    .speed_match_flag, .speed_fault_flag, .speed_fault_alarm, .coast_stop, .alarm_variant,
    .term_out, .irq);
always #5 aclk = ~aclk;
// Ends the run once, with the counts and the verdict.
task automatic print_verdict;
    $display("compares %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
endtask
// Compares a seen value with the expected one.
task automatic chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
        miscompares++;
        $display("[FAIL] t=%0t seen %h exp %h", $time, s, e);
    end
endtask
// Write: each channel is released at the rising edge that takes it; bresp lands in br.
task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
        @(posedge aclk);
        if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
        if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
        br = s_axi_bresp;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'h0;
endtask
// Read: returns data and response taken at the rising edge that sees rvalid.
task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
        @(posedge aclk);
        if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
        v = s_axi_rdata;
        rs = s_axi_rresp;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'h0;
endtask
// A hang counts as a mismatch and closes the run.
always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin miscompares++; print_verdict; end
end
initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1;
    rd(`OFF_JCMD, d, r); chk(d, 32'h14);
    rd(`OFF_JDET, d, r); chk(d, 32'h5);
    rd(`OFF_JOUT, d, r); chk(d, 32'h2);
    rd(`OFF_HYST, d, r); chk(d, 32'h64);
    rd(`OFF_TMR, d, r); chk(d, 32'h32);
    rd(`OFF_PROC, d, r); chk(d, 32'h2);
    rd(8'h3c, d, r); chk(r, 32'h2);
    // Just past the top of the range must be ignored.
    wr(`OFF_JCMD, 32'h1389); rd(`OFF_JCMD, d, r); chk(d, 32'h14);
    wr(`OFF_JINT, 32'h3e7); jog_pin <= 1; repeat (6) @(posedge aclk);
    chk(sel_gain, 32'h64);
    chk(sel_integ_en, 32'h0);
    chk(sel_itime, 32'h3e7);
    chk(sel_cmd_filt, 32'h14);
    chk(sel_det_filt, 32'h5);
    chk(sel_out_filt, 32'h2);
    jog_pin <= 0; repeat (6) @(posedge aclk); chk(sel_gain, 32'h2a);
    chk({sel_cmd_filt, sel_det_filt, sel_out_filt}, {13'h0007, 7'h03, 7'h04});
    chk({sel_itime, sel_integ_en}, {14'h0050, 1'h1});
    wr(`OFF_CTRL, 32'h5); wr(`OFF_NOTCH, 32'h0500); repeat (3) @(posedge aclk);
    chk(notch_en, 32'h2);
    wr(`OFF_NOTCH, 32'h0); repeat (3) @(posedge aclk); chk(notch_en, 32'h0);
    wr(`OFF_CTRL, 32'h0); wr(`OFF_NOTCH, 32'h01010101); repeat (3) @(posedge aclk);
    chk(notch_en, 32'hf);
    wr(`OFF_TMR, 32'h2); wr(`OFF_OFUNC0, 32'h4c47); wr(`OFF_IMASK, 32'h1);
    chk(speed_match_flag, 32'h1);
    det_speed <= 16'sd200; repeat (2) @(posedge aclk); chk(speed_match_flag, 32'h1);
    repeat (30) @(posedge aclk);
    chk(speed_match_flag, 32'h0);
    chk(speed_fault_flag, 32'h1);
    chk({coast_stop, speed_fault_alarm, alarm_variant}, 32'hd);
    chk(term_out[1:0], 32'h2);
    chk(irq, 32'h1);
    rd(`OFF_ISTAT, d, r); chk(d, 32'h3);
    det_speed <= 16'sd0; wr(`OFF_CTRL, 32'h100); wr(`OFF_ISTAT, 32'h3); repeat (20) @(posedge aclk);
    chk({speed_fault_flag, irq, term_out[0]}, 32'h1);
    // Code 3 excuses a lagging motor and only warns when it runs ahead.
    wr(`OFF_PROC, 32'h6); chk(br, 32'h0);
    wr(`OFF_PROC, 32'h3); rd(`OFF_PROC, d, r); chk(d, 32'h3);
    det_speed <= -16'sd200; repeat (30) @(posedge aclk);
    chk({speed_match_flag, speed_fault_flag, coast_stop}, 32'h0);
    det_speed <= 16'sd200; repeat (30) @(posedge aclk);
    chk({speed_fault_flag, coast_stop, term_out[1]}, 32'h5);
    det_speed <= 16'sd0; repeat (30) @(posedge aclk);
    chk({speed_match_flag, speed_fault_flag}, 32'h2);
    wr(8'h3c, 32'h1); chk(br, 32'h2);
    print_verdict;
end
endmodule
